// ---- src/farspg_pkg.sv ----
/*
  Shared constants, register layout and state type of the flash array read,
  shadow and program gate. Assumes address bit n of the bus numbering maps to
  addr[31-n] of the little-endian vectors used here.
*/
package farspg_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int N_BLK = 8;
  localparam int N_RPB = 2;
  localparam int PAGE_WORDS = 8;
  localparam int PAGE_BITS = 256;
  localparam int TAG_W = 13;
  localparam int WSEL_W = 3;
  localparam int PGW_W = 4;
  localparam int SPG_W = 3;
  localparam int A_WORD_LSB = 2;
  localparam int A_WORD_MSB = 4;
  localparam int A_PAGE_LSB = 5;
  localparam int A_PAGE_MSB = 7;
  localparam int A_PGW_MSB = 5;
  localparam int A_TAG_MSB = 17;
  localparam int A_RPB_BIT = 17;
  localparam int A_MAP_LSB = 18;
  localparam int A_MAP_MSB = 21;
  localparam int A_TOP_LSB = 25;
  localparam int A_REG_LSB = 4;
  localparam int A_OFS_MSB = 3;
  localparam logic [3:0] ARRAY_MAP = 4'h0;
  localparam logic [6:0] TOP_ZERO = 7'h00;
  localparam logic [27:0] REG_BASE = 28'h002FC80;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PROT = 4'h4;
  localparam logic [3:0] OFS_CFG = 4'h8;
  localparam int CTRL_HVE = 0;
  localparam int CTRL_SETUP = 1;
  localparam int CTRL_PE = 2;
  localparam int CTRL_SHADOW = 3;
  localparam int CTRL_BLK_LSB = 8;
  localparam int CTRL_DIS = 16;
  localparam int CTRL_PGMW = 17;
  localparam int PROT_LOCK_LSB = 0;
  localparam int PROT_RLOCK_LSB = 8;
  localparam int PROT_OVR = 10;
  localparam int CFG_PRESENT_N_BIT = 11;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PROT_RST = 32'h0000_0400;
  localparam logic [31:0] CFG_RST = 32'hFFFF_FFFF;
  localparam logic [1:0] RLOCK_ALL1 = 2'h3;
  localparam logic [1:0] RLOCK_ALL0 = 2'h0;
  localparam logic [7:0] BUF0_ONLY = 8'h01;
  localparam logic [2:0] MARGIN_CLKS = 3'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_MARGIN, ST_FETCH} farspg_state_t;
endpackage

// ---- src/farspg_rpb_if.sv ----
/*
  Carrier between the gate and its read page buffer monitor.
  Assumes one lookup and at most one load per clock.
*/
`timescale 1ns/1ps
interface farspg_rpb_if;
  logic inv;
  logic load;
  logic sel;
  logic [farspg_pkg::TAG_W-1:0] tag;
  logic [farspg_pkg::WSEL_W-1:0] word;
  logic [farspg_pkg::PAGE_BITS-1:0] page;
  logic hit;
  logic [farspg_pkg::DATA_W-1:0] rdata;
  modport ctl (output inv, load, sel, tag, word, page, input hit, rdata);
  modport mon (input inv, load, sel, tag, word, page, output hit, rdata);
endinterface

// ---- src/farspg_rpb.sv ----
/*
  Two read page buffers with address tags and valid status.
  Assumes the gate never loads and invalidates the same buffer in one clock
  with intent; invalidation wins so stale pages are never served.
*/
`timescale 1ns/1ps
module farspg_rpb (
  input wire logic clk_i,
  input wire logic rst_n_i,
  farspg_rpb_if.mon rpb
);
  logic [farspg_pkg::N_RPB-1:0] valid;
  logic [farspg_pkg::TAG_W-1:0] tags [farspg_pkg::N_RPB];
  logic [farspg_pkg::DATA_W-1:0] mem [farspg_pkg::N_RPB][farspg_pkg::PAGE_WORDS];

  genvar gb, gw;
  generate
    for (gb = 0; gb < farspg_pkg::N_RPB; gb++) begin : g_buf
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          valid[gb] <= 1'b0;
          tags[gb] <= '0;
        end else if (rpb.inv) begin
          valid[gb] <= 1'b0;
        end else if (rpb.load && (rpb.sel == 1'(gb))) begin
          valid[gb] <= 1'b1;
          tags[gb] <= rpb.tag;
        end
      end
      for (gw = 0; gw < farspg_pkg::PAGE_WORDS; gw++) begin : g_word
        always_ff @(posedge clk_i or negedge rst_n_i) begin
          if (!rst_n_i) begin
            mem[gb][gw] <= '0;
          end else if (rpb.load && (rpb.sel == 1'(gb))) begin
            mem[gb][gw] <= rpb.page[gw*farspg_pkg::DATA_W +: farspg_pkg::DATA_W];
          end
        end
      end
    end
  endgenerate

  assign rpb.hit = valid[rpb.sel] && (tags[rpb.sel] == rpb.tag);
  assign rpb.rdata = mem[rpb.sel][rpb.word];
endmodule

// ---- src/farspg_top.sv ----
/*
  Read gate, shadow selection and programming gate of an on-chip flash array.
  Assumes the bus master issues one request at a time and waits for ack_o,
  and that the array core answers a page read in the same clock that array_rd_o is high.
*/
`timescale 1ns/1ps
module farspg_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic sup_data_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [255:0] array_page_i,
  input wire logic [31:0] array_cfg_i,
  input wire logic ext_prog_en_i,
  input wire logic sys_cfg_req_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o,
  output logic array_rd_o,
  output logic [12:0] array_page_o,
  output logic array_shadow_o,
  output logic array_margin_o,
  output logic pgm_we_o,
  output logic [7:0] pgm_buf_o,
  output logic [3:0] pgm_word_o,
  output logic [31:0] pgm_clear_o,
  output logic [7:0] hv_block_o,
  output logic hv_erase_o,
  output logic [31:0] cfg_word_o,
  output logic cfg_valid_o
);
  function automatic logic is_reg(input logic [31:0] a);
    return a[31:farspg_pkg::A_REG_LSB] == farspg_pkg::REG_BASE;
  endfunction

  function automatic logic is_arr(input logic [31:0] a);
    return (a[31:farspg_pkg::A_TOP_LSB] == farspg_pkg::TOP_ZERO) &&
           (a[farspg_pkg::A_MAP_MSB:farspg_pkg::A_MAP_LSB] == farspg_pkg::ARRAY_MAP) && !is_reg(a);
  endfunction

  farspg_rpb_if rpb ();

  farspg_rpb u_rpb (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rpb(rpb.mon)
  );

  farspg_pkg::farspg_state_t state;
  logic hve;
  logic setup;
  logic pe;
  logic shadow;
  logic disable_mod;
  logic [7:0] blk_sel;
  logic [7:0] wr_lock;
  logic [1:0] read_lock_field;
  logic read_lock_field_ovr;
  logic pgm_seen;
  logic erase_seen;
  logic writes_closed;
  logic [31:0] cfg;
  logic [2:0] mcnt;
  logic [farspg_pkg::TAG_W-1:0] q_tag;
  logic [farspg_pkg::WSEL_W-1:0] q_word;
  logic q_sel;
  logic q_shadow;

  logic take;
  logic take_reg_wr;
  logic take_reg_rd;
  logic take_arr_wr;
  logic take_arr_rd;
  logic refused;
  logic lookup;
  logic margin_mode;
  logic pgm_write;
  logic erase_write;
  logic next_shadow;
  logic next_hve;
  logic next_setup;
  logic invalidate;
  logic [farspg_pkg::TAG_W-1:0] lk_tag;
  logic [farspg_pkg::WSEL_W-1:0] lk_word;
  logic lk_sel;
  logic [7:0] act_buf;
  logic [31:0] reg_rdata;
  logic [3:0] ofs;

  assign ofs = addr_i[farspg_pkg::A_OFS_MSB:0];
  assign take = (state == farspg_pkg::ST_IDLE) && req_i;
  assign take_reg_wr = take && wr_i && is_reg(addr_i);
  assign take_reg_rd = take && !wr_i && is_reg(addr_i);
  assign take_arr_wr = take && wr_i && is_arr(addr_i);
  assign take_arr_rd = take && !wr_i && is_arr(addr_i);
  assign margin_mode = setup && (pgm_seen || erase_seen) && !hve;

  // A shadow read that is not supervisor data has nothing to return, so it is refused too.
  assign refused = soft_rst_i || disable_mod || (shadow && !sup_data_i) ||
                   (!read_lock_field_ovr && ((read_lock_field == farspg_pkg::RLOCK_ALL1) ||
                                    (read_lock_field == farspg_pkg::RLOCK_ALL0)));

  // Shadow pages drop block and row bits so 256 bytes repeat over the whole array.
  always_comb begin
    if (shadow) begin
      lk_tag = {{(farspg_pkg::TAG_W-farspg_pkg::SPG_W){1'b0}},
                addr_i[farspg_pkg::A_PAGE_MSB:farspg_pkg::A_PAGE_LSB]};
      lk_sel = 1'b0;
    end else begin
      lk_tag = addr_i[farspg_pkg::A_TAG_MSB:farspg_pkg::A_PAGE_LSB];
      lk_sel = addr_i[farspg_pkg::A_RPB_BIT];
    end
    lk_word = addr_i[farspg_pkg::A_WORD_MSB:farspg_pkg::A_WORD_LSB];
  end

  assign lookup = (take_arr_rd && !refused && !hve) || ((state == farspg_pkg::ST_STALL) && !hve);

  always_comb begin
    rpb.load = (state == farspg_pkg::ST_FETCH);
    rpb.page = array_page_i;
    if (state == farspg_pkg::ST_IDLE) begin
      rpb.tag = lk_tag;
      rpb.sel = lk_sel;
      rpb.word = lk_word;
    end else begin
      rpb.tag = q_tag;
      rpb.sel = q_sel;
      rpb.word = q_word;
    end
  end

  assign pgm_write = take_arr_wr && setup && !pe && !hve && !writes_closed;
  assign erase_write = take_arr_wr && setup && pe && !hve && !writes_closed;

  always_comb begin
    next_shadow = shadow;
    next_setup = setup;
    next_hve = hve;
    if (take_reg_wr && (ofs == farspg_pkg::OFS_CTRL)) begin
      if (!(setup && !pe)) begin
        next_shadow = wdata_i[farspg_pkg::CTRL_SHADOW];
      end
      next_setup = wdata_i[farspg_pkg::CTRL_SETUP];
      // High voltage can only rise once setup is held and the buffers were written.
      next_hve = wdata_i[farspg_pkg::CTRL_HVE] && setup && next_setup && (pgm_seen || erase_seen);
    end
  end

  assign invalidate = soft_rst_i || pgm_write || erase_write || (next_hve && !hve) ||
                      (setup && !next_setup) || (next_shadow != shadow);
  assign rpb.inv = invalidate;

  always_comb begin
    case (ofs)
      farspg_pkg::OFS_CTRL: begin
        reg_rdata = '0;
        reg_rdata[farspg_pkg::CTRL_HVE] = hve;
        reg_rdata[farspg_pkg::CTRL_SETUP] = setup;
        reg_rdata[farspg_pkg::CTRL_PE] = pe;
        reg_rdata[farspg_pkg::CTRL_SHADOW] = shadow;
        reg_rdata[farspg_pkg::CTRL_BLK_LSB +: farspg_pkg::N_BLK] = blk_sel;
        reg_rdata[farspg_pkg::CTRL_DIS] = disable_mod;
        reg_rdata[farspg_pkg::CTRL_PGMW] = pgm_seen;
      end
      farspg_pkg::OFS_PROT: begin
        reg_rdata = '0;
        reg_rdata[farspg_pkg::PROT_LOCK_LSB +: farspg_pkg::N_BLK] = wr_lock;
        reg_rdata[farspg_pkg::PROT_RLOCK_LSB +: 2] = read_lock_field;
        reg_rdata[farspg_pkg::PROT_OVR] = read_lock_field_ovr;
      end
      farspg_pkg::OFS_CFG: reg_rdata = cfg;
      default: reg_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hve <= farspg_pkg::CTRL_RST[farspg_pkg::CTRL_HVE];
      setup <= farspg_pkg::CTRL_RST[farspg_pkg::CTRL_SETUP];
      pe <= farspg_pkg::CTRL_RST[farspg_pkg::CTRL_PE];
      shadow <= farspg_pkg::CTRL_RST[farspg_pkg::CTRL_SHADOW];
      disable_mod <= farspg_pkg::CTRL_RST[farspg_pkg::CTRL_DIS];
      blk_sel <= farspg_pkg::CTRL_RST[farspg_pkg::CTRL_BLK_LSB +: farspg_pkg::N_BLK];
      wr_lock <= farspg_pkg::PROT_RST[farspg_pkg::PROT_LOCK_LSB +: farspg_pkg::N_BLK];
      read_lock_field <= farspg_pkg::PROT_RST[farspg_pkg::PROT_RLOCK_LSB +: 2];
      read_lock_field_ovr <= farspg_pkg::PROT_RST[farspg_pkg::PROT_OVR];
    end else if (soft_rst_i) begin
      hve <= 1'b0;
      setup <= 1'b0;
      shadow <= 1'b0;
    end else begin
      hve <= next_hve;
      setup <= next_setup;
      shadow <= next_shadow;
      if (take_reg_wr && (ofs == farspg_pkg::OFS_CTRL)) begin
        pe <= wdata_i[farspg_pkg::CTRL_PE];
        disable_mod <= wdata_i[farspg_pkg::CTRL_DIS];
        blk_sel <= wdata_i[farspg_pkg::CTRL_BLK_LSB +: farspg_pkg::N_BLK];
      end
      if (take_reg_wr && (ofs == farspg_pkg::OFS_PROT)) begin
        wr_lock <= wdata_i[farspg_pkg::PROT_LOCK_LSB +: farspg_pkg::N_BLK];
        read_lock_field <= wdata_i[farspg_pkg::PROT_RLOCK_LSB +: 2];
        read_lock_field_ovr <= wdata_i[farspg_pkg::PROT_OVR];
      end
    end
  end

  // Buffer writes close when the pulse starts and reopen only after setup drops.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pgm_seen <= 1'b0;
      erase_seen <= 1'b0;
      writes_closed <= 1'b0;
    end else if (soft_rst_i || !next_setup) begin
      pgm_seen <= 1'b0;
      erase_seen <= 1'b0;
      writes_closed <= 1'b0;
    end else begin
      pgm_seen <= pgm_seen || pgm_write;
      erase_seen <= erase_seen || erase_write;
      writes_closed <= writes_closed || next_hve;
    end
  end

  assign act_buf = (shadow ? farspg_pkg::BUF0_ONLY : blk_sel) & ~wr_lock;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pgm_we_o <= 1'b0;
      pgm_buf_o <= '0;
      pgm_word_o <= '0;
      pgm_clear_o <= '0;
      hv_block_o <= '0;
      hv_erase_o <= 1'b0;
    end else begin
      pgm_we_o <= pgm_write && (act_buf != '0);
      if (pgm_write) begin
        pgm_buf_o <= act_buf;
        pgm_word_o <= addr_i[farspg_pkg::A_PGW_MSB:farspg_pkg::A_WORD_LSB];
        pgm_clear_o <= ~wdata_i;
      end
      hv_block_o <= (hve && ext_prog_en_i) ? act_buf : '0;
      hv_erase_o <= hve && ext_prog_en_i && pe;
    end
  end

  // The word is forced blank while block zero erases and otherwise follows the array sense lines, so the erase shows as absent.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= farspg_pkg::CFG_RST;
      cfg_word_o <= farspg_pkg::CFG_RST;
      cfg_valid_o <= 1'b0;
    end else begin
      if (hve && pe && ext_prog_en_i && act_buf[0]) begin
        cfg <= farspg_pkg::CFG_RST;
      end else begin
        cfg <= array_cfg_i;
      end
      cfg_word_o <= cfg;
      cfg_valid_o <= sys_cfg_req_i && !cfg[farspg_pkg::CFG_PRESENT_N_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= farspg_pkg::ST_IDLE;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= '0;
      array_rd_o <= 1'b0;
      array_page_o <= '0;
      array_shadow_o <= 1'b0;
      array_margin_o <= 1'b0;
      mcnt <= '0;
      q_tag <= '0;
      q_word <= '0;
      q_sel <= 1'b0;
      q_shadow <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      array_rd_o <= 1'b0;
      if (take) begin
        q_tag <= lk_tag;
        q_word <= lk_word;
        q_sel <= lk_sel;
        q_shadow <= shadow;
      end
      case (state)
        farspg_pkg::ST_IDLE: begin
          if (take_reg_rd) begin
            ack_o <= 1'b1;
            rdata_o <= reg_rdata;
          end else if (take && (wr_i || !is_arr(addr_i))) begin
            ack_o <= 1'b1;
          end else if (take_arr_rd && refused) begin
            ack_o <= 1'b1;
            err_o <= 1'b1;
            rdata_o <= '0;
          end else if (take_arr_rd && hve) begin
            state <= farspg_pkg::ST_STALL;
          end
        end
        farspg_pkg::ST_STALL: begin
          if (soft_rst_i) begin
            state <= farspg_pkg::ST_IDLE;
            ack_o <= 1'b1;
            err_o <= 1'b1;
          end
        end
        farspg_pkg::ST_MARGIN: begin
          mcnt <= mcnt + 3'h1;
          if (mcnt == farspg_pkg::MARGIN_CLKS - 3'h1) begin
            array_rd_o <= 1'b1;
            state <= farspg_pkg::ST_FETCH;
          end
        end
        farspg_pkg::ST_FETCH: begin
          ack_o <= 1'b1;
          rdata_o <= array_page_i[q_word*farspg_pkg::DATA_W +: farspg_pkg::DATA_W];
          state <= farspg_pkg::ST_IDLE;
        end
        default: state <= farspg_pkg::ST_IDLE;
      endcase
      if (lookup && !soft_rst_i) begin
        if (rpb.hit && !invalidate) begin
          ack_o <= 1'b1;
          rdata_o <= rpb.rdata;
          state <= farspg_pkg::ST_IDLE;
        end else begin
          array_page_o <= rpb.tag;
          array_shadow_o <= (state == farspg_pkg::ST_IDLE) ? shadow : q_shadow;
          array_margin_o <= margin_mode;
          mcnt <= '0;
          if (margin_mode) begin
            state <= farspg_pkg::ST_MARGIN;
          end else begin
            array_rd_o <= 1'b1;
            state <= farspg_pkg::ST_FETCH;
          end
        end
      end
    end
  end
endmodule

// ---- bench/farspg_checker.sv ----
/*
  Assertions on the ports of farspg_top.
  Assumes one bus request at a time, made only while the gate is idle.
*/
`timescale 1ns/1ps
module farspg_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] array_cfg_i,
  input wire logic ext_prog_en_i,
  input wire logic sys_cfg_req_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic array_rd_o,
  input wire logic [12:0] array_page_o,
  input wire logic array_shadow_o,
  input wire logic [7:0] hv_block_o,
  input wire logic hv_erase_o,
  input wire logic [31:0] cfg_word_o,
  input wire logic cfg_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic arr_rd;
  assign arr_rd = req_i && !wr_i && addr_i[31:25] == 7'h00 && addr_i[21:18] == 4'h0;
  sequence stall_req;
    hv_block_o != 8'h00 && !$past(soft_rst_i) && !soft_rst_i && arr_rd;
  endsequence
  sequence quiet3;
    !soft_rst_i [*3];
  endsequence
  hv_gate_a: assert property (!ext_prog_en_i |=> hv_block_o == 8'h00 && !hv_erase_o)
    else $error("voltage without enable");
  read_stall_a: assert property (stall_req ##1 quiet3 |-> !ack_o && !$past(ack_o) && !$past(ack_o, 2))
    else $error("read acked under voltage");
  soft_refuse_a: assert property (soft_rst_i && arr_rd |=> ack_o && err_o)
    else $error("read not refused in reset");
  refuse_ack_a: assert property (err_o |-> ack_o)
    else $error("refusal without answer");
  reg_reach_a: assert property (req_i && addr_i[31:4] == farspg_pkg::REG_BASE |=> ack_o && !err_o && !array_rd_o)
    else $error("register access diverted");
  fetch_answer_a: assert property (array_rd_o |-> !ack_o ##1 ack_o)
    else $error("fetch answer timing");
  shadow_row_a: assert property (array_rd_o && array_shadow_o |-> array_page_o[12:3] == 10'h000)
    else $error("shadow fetch uses row bits");
  cfg_valid_a: assert property (rst_n_i && sys_cfg_req_i && !array_cfg_i[11] && !hv_erase_o ##1 sys_cfg_req_i && !hv_erase_o |=> cfg_valid_o)
    else $error("config word not offered");
  cfg_absent_a: assert property (array_cfg_i[11] |-> ##2 !cfg_valid_o)
    else $error("absent config offered");
  cfg_word_a: assert property ((rst_n_i && $stable(array_cfg_i)) [*3] |-> cfg_word_o == array_cfg_i)
    else $error("config word mismatch");
endmodule
bind farspg_top farspg_checker i_farspg_checker (.clk_i, .rst_n_i, .soft_rst_i, .req_i, .wr_i, .addr_i,
  .array_cfg_i, .ext_prog_en_i, .sys_cfg_req_i, .ack_o, .err_o, .array_rd_o, .array_page_o,
  .array_shadow_o, .hv_block_o, .hv_erase_o, .cfg_word_o, .cfg_valid_o);

// ---- bench/farspg_array_model.sv ----
/*
  Behavioural array core: page fetches and the configuration word.
  Assumes the page is taken in the fetch cycle or the one after.
*/
`timescale 1ns/1ps
module farspg_array_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic array_rd_i,
  input wire logic [12:0] page_i,
  input wire logic shadow_i,
  input wire logic margin_i,
  input wire logic [7:0] hv_block_i,
  input wire logic hv_erase_i,
  input wire logic [31:0] cfg_seed_i,
  output logic [255:0] page_o,
  output logic [31:0] cfg_o
);
  logic rd_q;
  logic erased;
  logic [31:0] noise;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q <= 1'h0;
      noise <= 32'h0000_0000;
    end else begin
      rd_q <= array_rd_i;
      noise <= ~noise;
    end
  end
  // Erasing block 0 wipes the shadow row, so the word then reads absent.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      erased <= 1'h0;
    end else if (hv_erase_i && hv_block_i[0]) begin
      erased <= 1'h1;
    end
  end
  assign cfg_o = erased ? 32'hFFFF_FFFF : cfg_seed_i;
  // Outside a fetch the page toggles, so a late sample cannot match.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      page_o[32*k +: 32] = (array_rd_i || rd_q) ?
        {shadow_i ? 8'hC3 : 8'h3C, 3'h0, page_i, margin_i ? 4'hF : 4'h0, 4'(k)} : noise;
    end
  end
endmodule

// ---- bench/farspg_top_tb.sv ----
/*
  Self-checking bench for farspg_top driving its bus and program pin.
  Assumes the array model behind it and the bound checker.
*/
`timescale 1ns/1ps
module farspg_top_tb;
  localparam logic [31:0] CTRL = {farspg_pkg::REG_BASE, farspg_pkg::OFS_CTRL};
  localparam logic [31:0] PROT = {farspg_pkg::REG_BASE, farspg_pkg::OFS_PROT};
  localparam logic [31:0] CFG = {farspg_pkg::REG_BASE, farspg_pkg::OFS_CFG};
  localparam logic [31:0] SEED = 32'h1234_5000;
  localparam logic [31:0] A = 32'h0000_1124;
  localparam logic [31:0] P = 32'h0000_8034;
  localparam logic N = 1'h0;
  localparam logic Y = 1'h1;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic soft_rst_i = 1'h0;
  logic req_i = 1'h0;
  logic wr_i = 1'h0;
  logic sup_data_i = 1'h0;
  logic [31:0] addr_i = 32'h0000_0000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic ext_prog_en_i = 1'h0;
  logic sys_cfg_req_i = 1'h1;
  logic [255:0] array_page_i;
  logic [31:0] array_cfg_i, rdata_o, pgm_clear_o, cfg_word_o, s_rd, s_clr;
  logic ack_o, err_o, array_rd_o, array_shadow_o, array_margin_o, pgm_we_o, hv_erase_o, cfg_valid_o;
  logic [12:0] array_page_o;
  logic [7:0] pgm_buf_o, hv_block_o, s_buf;
  logic [3:0] pgm_word_o, s_word;
  logic s_err, s_we;
  int s_lat;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  farspg_top i_farspg_top (.clk_i, .rst_n_i, .soft_rst_i, .req_i, .wr_i, .sup_data_i, .addr_i, .wdata_i,
    .array_page_i, .array_cfg_i, .ext_prog_en_i, .sys_cfg_req_i, .ack_o, .err_o, .rdata_o, .array_rd_o,
    .array_page_o, .array_shadow_o, .array_margin_o, .pgm_we_o, .pgm_buf_o, .pgm_word_o, .pgm_clear_o,
    .hv_block_o, .hv_erase_o, .cfg_word_o, .cfg_valid_o);
  farspg_array_model i_farspg_array_model (.clk_i, .rst_n_i, .array_rd_i(array_rd_o), .page_i(array_page_o),
    .shadow_i(array_shadow_o), .margin_i(array_margin_o), .hv_block_i(hv_block_o), .hv_erase_i(hv_erase_o),
    .cfg_seed_i(SEED), .page_o(array_page_i), .cfg_o(array_cfg_i));
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Outputs are read at the edge, so they show the cycle just ended.
  task automatic start(input logic wr, input logic sup, input logic [31:0] a, input logic [31:0] d);
    req_i <= 1'h1;
    wr_i <= wr;
    sup_data_i <= sup;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'h0;
  endtask
  task automatic await();
    s_lat = 0;
    do begin
      @(posedge clk_i);
      s_lat++;
    end while (ack_o !== 1'h1 && s_lat < 50);
    s_rd = rdata_o;
    s_err = err_o;
    s_we = pgm_we_o;
    s_buf = pgm_buf_o;
    s_word = pgm_word_o;
    s_clr = pgm_clear_o;
    if (s_lat >= 50) chk("answer", 32'h1, 32'h0);
  endtask
  task automatic rw(input logic [31:0] a, input logic [31:0] d);
    start(Y, Y, a, d);
    await();
  endtask
  task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
    start(N, Y, a, 32'h0);
    await();
    chk("register", exp, s_rd);
    chk("register latency", 32'h1, 32'(s_lat));
  endtask
  task automatic rdx(input logic [31:0] a, input logic sup, input logic sh, input logic mg, input logic ee,
                     input int el);
    logic [31:0] exp;
    exp = {sh ? 8'hC3 : 8'h3C, 3'h0, sh ? {10'h000, a[7:5]} : a[17:5], mg ? 4'hF : 4'h0, 1'h0, a[4:2]};
    start(N, sup, a, 32'h0);
    await();
    chk("read data", ee ? 32'h0 : exp, s_rd);
    chk("read refused", {31'h0, ee}, {31'h0, s_err});
    if (el > 0) chk("read latency", 32'(el), 32'(s_lat));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic t_reset();
    rreg(CTRL, farspg_pkg::CTRL_RST);
    rreg(PROT, farspg_pkg::PROT_RST);
    rreg(CTRL + 32'hC, 32'h0);
    rreg(CFG, SEED);
    chk("config valid", 32'h1, {31'h0, cfg_valid_o});
  endtask
  task automatic t_pages();
    rdx(A, N, N, N, N, 2);
    rdx(A + 32'h4, N, N, N, N, 1);
    rdx(32'h0002_0048, N, N, N, N, 2);
    rdx(A + 32'h8, N, N, N, N, 1);
  endtask
  task automatic t_refuse();
    rw(CTRL, 32'h0001_0000);
    rdx(A, N, N, N, Y, 1);
    rw(CTRL, 32'h0);
    for (int l = 0; l < 4; l++) begin
      rw(PROT, {22'h0, 2'(l), 8'h00});
      rdx(A, N, N, N, (l == 0 || l == 3), 0);
    end
    rw(PROT, farspg_pkg::PROT_RST);
    soft_rst_i <= Y;
    rdx(A, N, N, N, Y, 1);
    soft_rst_i <= N;
    rdx(A, N, N, N, N, 2);
  endtask
  task automatic t_shadow();
    rw(CTRL, 32'h8);
    rreg(CTRL, 32'h8);
    rdx(32'h0001_5F24, Y, Y, N, N, 2);
    rdx(A, Y, Y, N, N, 0);
    rdx(A, N, Y, N, Y, 1);
    rw(CTRL, 32'h0);
    rdx(A, N, N, N, N, 2);
  endtask
  task automatic t_program();
    rw(PROT, 32'h0000_0404);
    rw(CTRL, 32'h0000_0602);
    rw(P, 32'hFFFF_0F0F);
    chk("program strobe", 32'h1, {31'h0, s_we});
    chk("program buffers", 32'h2, {24'h0, s_buf});
    chk("program word", 32'hD, {28'h0, s_word});
    chk("program bits", 32'h0000_F0F0, s_clr);
    rdx(P, N, N, Y, N, 6);
    rw(CTRL, 32'h0000_060A);
    rreg(CTRL, 32'h0002_0602);
    rw(CTRL, 32'h0000_0603);
    idle(2);
    chk("voltage off", 32'h0, {24'h0, hv_block_o});
    ext_prog_en_i <= Y;
    idle(2);
    chk("voltage on", 32'h2, {24'h0, hv_block_o});
    start(N, N, P, 32'h0);
    repeat (8) begin
      @(posedge clk_i);
      chk("stalled answer", 32'h0, {31'h0, ack_o});
    end
    soft_rst_i <= Y;
    await();
    soft_rst_i <= N;
    chk("stall refused", 32'h1, {31'h0, s_err});
    ext_prog_en_i <= N;
    rw(CTRL, 32'h8);
    rw(CTRL, 32'h0000_060A);
    rw(P, 32'h0000_FFFF);
    chk("shadow buffer", 32'h1, {24'h0, s_buf});
  endtask
  task automatic t_erase();
    soft_rst_i <= Y;
    idle(1);
    soft_rst_i <= N;
    rw(CTRL, 32'h0000_0106);
    rw(A, 32'h0);
    ext_prog_en_i <= Y;
    rw(CTRL, 32'h0000_0107);
    idle(2);
    chk("erase voltage", 32'h1, {31'h0, hv_erase_o});
    idle(3);
    chk("config absent", 32'h0, {31'h0, cfg_valid_o});
    ext_prog_en_i <= N;
    rreg(CFG, 32'hFFFF_FFFF);
  endtask
  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    idle(16);
    rst_n_i <= Y;
    idle(1);
    t_reset();
    t_pages();
    t_refuse();
    t_shadow();
    t_program();
    t_erase();
    finish_test();
  end
endmodule
